// ---- src/dcc_consts.svh ----
/*
  Constants of the audio converter control port: register indices,
  field positions, reset values and timing figures.
  Assumes inclusion by bare name from the modules and the bench.
*/
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH

// Register indices carried in the low three bits of the sub-address
`define DCC_IDX_LEFT_GAIN 3'h0
`define DCC_IDX_RIGHT_GAIN 3'h1
`define DCC_IDX_MODE 3'h2
`define DCC_IDX_FMT_CLK_RATE_CTL 3'h3
`define DCC_IDX_OUTPUT_CTL 3'h4
`define DCC_IDX_W 3

// Fields of format_clock_rate_control
`define DCC_B_SERIAL_FMT 0
`define DCC_B_FRAME_POL 1
`define DCC_B_COMMON_ATT 2
`define DCC_B_CLK_RATIO 3
`define DCC_F_RATE_MULT_LO 4
`define DCC_F_RATE_GROUP_LO 6

// Fields of output_control
`define DCC_B_ATT_LOAD 0
`define DCC_B_ZERO_MUTE 1
`define DCC_B_CONV_DIS 2

// Reset values
`define DCC_RST_LEFT_GAIN 8'hff
`define DCC_RST_RIGHT_GAIN 8'hff
`define DCC_RST_MODE 8'h90
`define DCC_RST_FMT_CLK_RATE_CTL 8'h00
`define DCC_RST_OUTPUT_CTL 8'h00

// Clock ratios, sampling-group base rates and unity gain
`define DCC_RATIO_384 9'h180
`define DCC_RATIO_256 9'h100
`define DCC_FS_GROUP_44K1 17'h0ac44
`define DCC_FS_GROUP_48K 17'h0bb80
`define DCC_FS_GROUP_32K 17'h07d00
`define DCC_GAIN_UNITY 9'h100

// Timing
`define DCC_SYS_CLK_MHZ 50
`define DCC_SCL_MAX_KHZ 100
`define DCC_SCL_HIGH_MIN_NS 4000
`define DCC_ZERO_RUN_BCK 65536

`endif

// ---- src/dcc_ctrl.sv ----
/*
  Write-only two-wire control port of a stereo audio converter, with
  its control registers and the decoded control outputs.
  Assumes an external open-drain wire built from sda_o and sda_oe_n_o,
  and an audio bit clock that is unrelated to clk_sys_i.
*/
`timescale 1ns/10ps
`include "dcc_consts.svh"

module dcc_ctrl #(
  parameter logic [4:0] ADDR_HI = 5'h13,
  parameter int ZERO_RUN = `DCC_ZERO_RUN_BCK
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic addr_strap_0_i,
  input wire logic addr_strap_1_i,
  input wire logic audio_bit_clock_i,
  input wire logic audio_data_i,
  input wire logic frame_channel_clock_i,
  output dcc_pkg::dcc_ctl_t ctl_o,
  output logic zero_n_o,
  output logic bus_busy_o
);
  import dcc_pkg::*;

  localparam int SCL_HIGH_CYC =
    (`DCC_SCL_HIGH_MIN_NS * `DCC_SYS_CLK_MHZ + 999) / 1000;
  localparam int SCL_BIT_CYC = (`DCC_SYS_CLK_MHZ * 1000) / `DCC_SCL_MAX_KHZ;

  if (SCL_HIGH_CYC < 4 || SCL_BIT_CYC < 8) begin : g_bad_clk
    $error("system clock too slow for the two-wire port");
  end

  dcc_ctrl_st_t s;
  dcc_ctrl_st_t n;
  logic zero_link;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [7:0] own_addr;

  function automatic logic [8:0] gain_of(input logic [7:0] code);
    if (code == 8'hff) begin
      return `DCC_GAIN_UNITY;
    end
    return {1'b0, code};
  endfunction

  function automatic logic [16:0] fs_of(input logic [1:0] grp,
                                        input logic [1:0] mult);
    logic [16:0] base;
    base = 17'h00000;
    if (grp == 2'b00) begin
      base = `DCC_FS_GROUP_44K1;
    end else if (grp == 2'b01) begin
      base = `DCC_FS_GROUP_48K;
    end else if (grp == 2'b10) begin
      base = `DCC_FS_GROUP_32K;
    end
    if (mult == 2'b01) begin
      return {base[15:0], 1'b0};
    end else if (mult == 2'b10) begin
      return {1'b0, base[16:1]};
    end else if (mult == 2'b00) begin
      return base;
    end
    return 17'h00000;
  endfunction

  dcc_zero_det #(
    .RUN(ZERO_RUN)
  ) u_zero (
    .audio_bit_clock_i(audio_bit_clock_i),
    .rst_n_i(rst_n_i),
    .audio_data_i(audio_data_i),
    .zero_o(zero_link)
  );

  // edges from second and third stages only
  assign scl_rise = s.scl_s2 & ~s.scl_s3;
  assign scl_fall = ~s.scl_s2 & s.scl_s3;
  // start and stop while clock high
  assign start_det = s.scl_s2 & s.scl_s3 & ~s.sda_s2 & s.sda_s3;
  assign stop_det = s.scl_s2 & s.scl_s3 & s.sda_s2 & ~s.sda_s3;
  // fixed high bits, strap low bits, write bit
  assign own_addr = {ADDR_HI, s.addr_lo, 1'b0};

  always_comb begin
    n = s;
    n.scl_s1 = scl_i;
    n.scl_s2 = s.scl_s1;
    n.scl_s3 = s.scl_s2;
    n.sda_s1 = sda_i;
    n.sda_s2 = s.sda_s1;
    n.sda_s3 = s.sda_s2;
    n.strap_s1 = {addr_strap_1_i, addr_strap_0_i};
    n.strap_s2 = s.strap_s1;
    n.frame_s1 = frame_channel_clock_i;
    n.frame_s2 = s.frame_s1;
    n.zero_s1 = zero_link;
    n.zero_s2 = s.zero_s1;
    n.addr_lo = s.strap_s2;

    if (start_det) begin
      n.busy = 1'b1;
      n.st = DCC_ADDR;
      n.bitcnt = 3'h0;
      n.byte_done = 1'b0;
      n.ack_drive = 1'b0;
    end else if (stop_det) begin
      n.busy = 1'b0;
      n.st = DCC_IDLE;
      n.byte_done = 1'b0;
      n.ack_drive = 1'b0;
    end else begin
      case (s.st)
        DCC_ADDR, DCC_SUB, DCC_DATA: begin
          if (scl_rise && !s.byte_done) begin
            n.shift = {s.shift[6:0], s.sda_s2};
            n.bitcnt = s.bitcnt + 3'h1;
            if (s.bitcnt == 3'h7) begin
              n.byte_done = 1'b1;
            end
          end else if (scl_fall && s.byte_done) begin
            n.byte_done = 1'b0;
            n.bitcnt = 3'h0;
            n.ack_drive = 1'b1;
            n.st = DCC_ACK;
            if (s.st == DCC_ADDR) begin
              n.after = DCC_SUB;
              if (s.shift != own_addr) begin
                n.ack_drive = 1'b0;
                n.st = DCC_IGNORE;
              end
            end else if (s.st == DCC_SUB) begin
              n.after = DCC_DATA;
              n.sub = s.shift[`DCC_IDX_W-1:0];
            end else begin
              n.after = DCC_IGNORE;
              if (s.sub <= `DCC_IDX_OUTPUT_CTL) begin
                n.regs[s.sub] = s.shift;
              end
            end
          end
        end
        DCC_ACK: begin
          // ack held for one clock pulse
          if (scl_fall) begin
            n.ack_drive = 1'b0;
            n.st = s.after;
          end
        end
        DCC_IGNORE: begin
          n.ack_drive = 1'b0;
        end
        default: begin
          n.ack_drive = 1'b0;
        end
      endcase
    end

    // load both channels together or hold
    if (s.regs[`DCC_IDX_OUTPUT_CTL][`DCC_B_ATT_LOAD]) begin
      n.gain_l = s.regs[`DCC_IDX_LEFT_GAIN];
      if (s.regs[`DCC_IDX_FMT_CLK_RATE_CTL][`DCC_B_COMMON_ATT]) begin
        n.gain_r = s.regs[`DCC_IDX_LEFT_GAIN];
      end else begin
        n.gain_r = s.regs[`DCC_IDX_RIGHT_GAIN];
      end
    end

    n.ctl.serial_format_select =
      s.regs[`DCC_IDX_FMT_CLK_RATE_CTL][`DCC_B_SERIAL_FMT];
    n.ctl.frame_polarity_select =
      s.regs[`DCC_IDX_FMT_CLK_RATE_CTL][`DCC_B_FRAME_POL];
    n.ctl.common_attenuation_select =
      s.regs[`DCC_IDX_FMT_CLK_RATE_CTL][`DCC_B_COMMON_ATT];
    n.ctl.output_clock_ratio_select =
      s.regs[`DCC_IDX_FMT_CLK_RATE_CTL][`DCC_B_CLK_RATIO];
    n.ctl.rate_multiplier = s.regs[`DCC_IDX_FMT_CLK_RATE_CTL]
      [`DCC_F_RATE_MULT_LO+:2];
    n.ctl.rate_group = s.regs[`DCC_IDX_FMT_CLK_RATE_CTL]
      [`DCC_F_RATE_GROUP_LO+:2];
    n.ctl.zero_detect_mute_enable =
      s.regs[`DCC_IDX_OUTPUT_CTL][`DCC_B_ZERO_MUTE];
    n.ctl.converter_disable = s.regs[`DCC_IDX_OUTPUT_CTL][`DCC_B_CONV_DIS];
    n.ctl.mode_bits = s.regs[`DCC_IDX_MODE];
    n.ctl.left_gain_code = s.gain_l;
    n.ctl.right_gain_code = s.gain_r;
    n.ctl.left_gain = gain_of(s.gain_l);
    n.ctl.right_gain = gain_of(s.gain_r);
    // I2S frame low is left; polarity unused there
    if (s.regs[`DCC_IDX_FMT_CLK_RATE_CTL][`DCC_B_SERIAL_FMT]) begin
      n.ctl.left_active = ~s.frame_s2;
    end else begin
      n.ctl.left_active = s.frame_s2 ^
        s.regs[`DCC_IDX_FMT_CLK_RATE_CTL][`DCC_B_FRAME_POL];
    end
    // disable or muted zero run gives mid-supply
    n.ctl.common_mode = s.regs[`DCC_IDX_OUTPUT_CTL][`DCC_B_CONV_DIS] |
      (s.regs[`DCC_IDX_OUTPUT_CTL][`DCC_B_ZERO_MUTE] & s.zero_s2);
    if (s.regs[`DCC_IDX_FMT_CLK_RATE_CTL][`DCC_B_CLK_RATIO]) begin
      n.ctl.mclk_ratio = `DCC_RATIO_256;
    end else begin
      n.ctl.mclk_ratio = `DCC_RATIO_384;
    end
    n.ctl.fs_hz = fs_of(n.ctl.rate_group, n.ctl.rate_multiplier);
    n.zero_n = ~s.zero_s2;
  end

  // Straps are copied only after release, never loaded during reset
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      s <= '0;
      s.scl_s1 <= 1'b1;
      s.scl_s2 <= 1'b1;
      s.scl_s3 <= 1'b1;
      s.sda_s1 <= 1'b1;
      s.sda_s2 <= 1'b1;
      s.sda_s3 <= 1'b1;
      s.st <= DCC_IDLE;
      s.after <= DCC_IDLE;
      s.regs[`DCC_IDX_LEFT_GAIN] <= `DCC_RST_LEFT_GAIN;
      s.regs[`DCC_IDX_RIGHT_GAIN] <= `DCC_RST_RIGHT_GAIN;
      s.regs[`DCC_IDX_MODE] <= `DCC_RST_MODE;
      s.regs[`DCC_IDX_FMT_CLK_RATE_CTL] <= `DCC_RST_FMT_CLK_RATE_CTL;
      s.regs[`DCC_IDX_OUTPUT_CTL] <= `DCC_RST_OUTPUT_CTL;
      s.gain_l <= `DCC_RST_LEFT_GAIN;
      s.gain_r <= `DCC_RST_RIGHT_GAIN;
      s.ctl.left_gain_code <= `DCC_RST_LEFT_GAIN;
      s.ctl.right_gain_code <= `DCC_RST_RIGHT_GAIN;
      s.ctl.left_gain <= `DCC_GAIN_UNITY;
      s.ctl.right_gain <= `DCC_GAIN_UNITY;
      s.ctl.mode_bits <= `DCC_RST_MODE;
      s.ctl.mclk_ratio <= `DCC_RATIO_384;
      s.ctl.fs_hz <= `DCC_FS_GROUP_44K1;
      s.zero_n <= 1'b1;
    end else if (ce_i) begin
      s <= n;
    end
  end

  // receiver only: the line is only ever pulled low
  assign sda_o = 1'b0;
  assign sda_oe_n_o = ~s.ack_drive;
  assign ctl_o = s.ctl;
  assign zero_n_o = s.zero_n;
  assign bus_busy_o = s.busy;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_busy_on_start: assert property (ce_i && start_det |=> bus_busy_o)
    else $error("bus not busy after start");
  chk_idle_on_stop: assert property (
    ce_i && stop_det && !start_det |=> s.st == DCC_IDLE && !bus_busy_o)
    else $error("stop did not free the bus");
  chk_ack_own_addr: assert property (
    ce_i && s.st == DCC_ADDR && s.byte_done && scl_fall && !start_det
    && !stop_det && s.shift == own_addr |=> !sda_oe_n_o)
    else $error("own address not acknowledged");
  chk_foreign_silent: assert property (
    s.st == DCC_IGNORE || s.st == DCC_IDLE |-> sda_oe_n_o)
    else $error("line driven while not addressed");
  chk_ack_release: assert property (
    ce_i && s.st == DCC_ACK && scl_fall && !start_det && !stop_det
    |=> sda_oe_n_o ##1 sda_oe_n_o)
    else $error("ack not released after its clock pulse");
  chk_load_hold: assert property (
    ce_i && !s.regs[`DCC_IDX_OUTPUT_CTL][`DCC_B_ATT_LOAD]
    |=> s.gain_l == $past(s.gain_l) && s.gain_r == $past(s.gain_r))
    else $error("attenuation changed while load is off");
  chk_common_atten: assert property (
    ce_i && s.regs[`DCC_IDX_OUTPUT_CTL][`DCC_B_ATT_LOAD]
    && s.regs[`DCC_IDX_FMT_CLK_RATE_CTL][`DCC_B_COMMON_ATT]
    |=> s.gain_r == $past(s.regs[`DCC_IDX_LEFT_GAIN]))
    else $error("right channel not following left code");
  chk_clock_ratio: assert property (
    ctl_o.mclk_ratio == (ctl_o.output_clock_ratio_select ?
    `DCC_RATIO_256 : `DCC_RATIO_384))
    else $error("clock ratio does not match select bit");
  chk_zero_flag: assert property (
    ce_i && s.zero_s2 |=> !zero_n_o)
    else $error("zero flag not raised");
  chk_disable_mid: assert property (
    ctl_o.converter_disable |-> ctl_o.common_mode)
    else $error("disabled converter not at mid-supply");
  chk_rate_reserved: assert property (
    ctl_o.rate_multiplier == 2'b11 || ctl_o.rate_group == 2'b11
    |-> ctl_o.fs_hz == 17'h00000)
    else $error("reserved rate code gave a rate");
  chk_frame_pol: assert property (
    ce_i && !s.regs[`DCC_IDX_FMT_CLK_RATE_CTL][`DCC_B_SERIAL_FMT]
    |=> ctl_o.left_active == ($past(s.frame_s2) ^ $past(
    s.regs[`DCC_IDX_FMT_CLK_RATE_CTL][`DCC_B_FRAME_POL])))
    else $error("frame polarity not applied");

  cov_write_done: cover property (s.st == DCC_ACK && s.after == DCC_IGNORE);
  cov_foreign: cover property (s.st == DCC_IGNORE && bus_busy_o);
  cov_repeat_start: cover property (start_det && bus_busy_o);
  cov_zero_run: cover property (!zero_n_o);

endmodule

// ---- src/dcc_pkg.sv ----
/*
  Types of the audio converter control port: states, the control
  carrier and the state records of both modules.
  Assumes dcc_consts.svh on the include path.
*/
package dcc_pkg;

  typedef enum logic [5:0] {
    DCC_IDLE = 6'b000001,
    DCC_ADDR = 6'b000010,
    DCC_SUB = 6'b000100,
    DCC_DATA = 6'b001000,
    DCC_ACK = 6'b010000,
    DCC_IGNORE = 6'b100000
  } dcc_st_t;

  typedef struct packed {
    logic serial_format_select;
    logic frame_polarity_select;
    logic common_attenuation_select;
    logic output_clock_ratio_select;
    logic [1:0] rate_multiplier;
    logic [1:0] rate_group;
    logic zero_detect_mute_enable;
    logic converter_disable;
    logic [7:0] mode_bits;
    logic [7:0] left_gain_code;
    logic [7:0] right_gain_code;
    logic [8:0] left_gain;
    logic [8:0] right_gain;
    logic left_active;
    logic common_mode;
    logic [8:0] mclk_ratio;
    logic [16:0] fs_hz;
  } dcc_ctl_t;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    logic [1:0] strap_s1;
    logic [1:0] strap_s2;
    logic frame_s1;
    logic frame_s2;
    logic zero_s1;
    logic zero_s2;
    logic [1:0] addr_lo;
    logic busy;
    dcc_st_t st;
    dcc_st_t after;
    logic [7:0] shift;
    logic [2:0] bitcnt;
    logic byte_done;
    logic ack_drive;
    logic [2:0] sub;
    logic [4:0][7:0] regs;
    logic [7:0] gain_l;
    logic [7:0] gain_r;
    dcc_ctl_t ctl;
    logic zero_n;
  } dcc_ctrl_st_t;

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic [16:0] cnt;
    logic zero;
  } dcc_zd_st_t;

endpackage

// ---- src/dcc_zero_det.sv ----
/*
  Zero-run detector on the audio bit clock.
  Assumes the bit clock may stop between frames; the flag then holds.
  The system reset arrives from the system domain and is re-timed here.
*/
`timescale 1ns/10ps
`include "dcc_consts.svh"

module dcc_zero_det #(
  parameter int RUN = `DCC_ZERO_RUN_BCK
) (
  input wire logic audio_bit_clock_i,
  input wire logic rst_n_i,
  input wire logic audio_data_i,
  output logic zero_o
);
  import dcc_pkg::*;

  localparam logic [16:0] RUN_LAST = 17'(RUN - 1);

  dcc_zd_st_t s;
  dcc_zd_st_t n;

  if (RUN < 2 || RUN > 65536) begin : g_bad_run
    $error("zero run length out of range");
  end

  always_comb begin
    n = s;
    n.rst_s1 = rst_n_i;
    n.rst_s2 = s.rst_s1;
    if (!s.rst_s2) begin
      n.cnt = 17'h00000;
      n.zero = 1'b0;
    end else if (audio_data_i) begin
      n.cnt = 17'h00000;
      n.zero = 1'b0;
    end else if (s.cnt >= RUN_LAST) begin
      n.zero = 1'b1;
    end else begin
      n.cnt = s.cnt + 17'h00001;
    end
  end

  always_ff @(posedge audio_bit_clock_i) begin
    s <= n;
  end

  assign zero_o = s.zero;

endmodule

// ---- tb/dcc_host_model.sv ----
/*
  Two-wire bus master model that writes the converter's registers.
  Assumes a pulled-up data wire resolved by the bench from sda_low_o.
*/
`timescale 1ns/10ps

module dcc_host_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // Short quarter bit keeps the run brief; sync needs only a few cycles
  localparam int Q = 10;

  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic wq;
    repeat (Q) @(posedge clk_i);
    #1;
  endtask

  task automatic start;
    sda_low_o = 1'b0;
    wq;
    scl_o = 1'b1;
    wq;
    sda_low_o = 1'b1;
    wq;
    scl_o = 1'b0;
    wq;
  endtask

  task automatic stop;
    sda_low_o = 1'b1;
    wq;
    scl_o = 1'b1;
    wq;
    sda_low_o = 1'b0;
    wq;
  endtask

  // data moves only while clock low
  task automatic clk_bit(input logic b, output logic seen);
    sda_low_o = ~b;
    wq;
    scl_o = 1'b1;
    wq;
    seen = sda_i;
    scl_o = 1'b0;
    wq;
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], s);
    end
    clk_bit(1'b1, s);
    ack = ~s;
  endtask

  // address, sub-address, data, then stop unless rs is set, which leaves the bus held for the caller
  task automatic write_reg(input logic [7:0] a, input logic [7:0] s,
                           input logic [7:0] d, input logic rs,
                           output logic [2:0] acks);
    start;
    send_byte(a, acks[2]);
    send_byte(s, acks[1]);
    send_byte(d, acks[0]);
    if (!rs) begin
      stop;
    end
  endtask
endmodule

// ---- tb/test_dcc_ctrl.sv ----
/*
  Self-checking bench of the converter control port.
  Assumes the host model drives the bus and the bit clock runs free.
*/
`timescale 1ns/10ps
`include "dcc_consts.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end

module test_dcc_ctrl;
  import dcc_pkg::*;
  localparam logic [7:0] DEV_W = {5'h13, 2'b10, 1'b0};
  int failures = 0;
  int compares = 0;
  logic clk_sys_i = 1'b0;
  logic audio_bit_clock = 1'b0;
  logic rst_n = 1'b0;
  logic data = 1'b1;
  logic frame = 1'b0;
  logic ce = 1'b1;
  logic scl;
  logic host_low;
  logic sda_o;
  logic sda_oe_n;
  logic sda;
  logic zero_n;
  logic busy;
  logic ack;
  logic [2:0] acks;
  dcc_ctl_t ctl;

  always #10 clk_sys_i = ~clk_sys_i;
  // Odd offset keeps the bit clock out of phase with the system clock
  initial #7 forever #15 audio_bit_clock = ~audio_bit_clock;
  assign sda = ~host_low & (sda_oe_n | sda_o);

  dcc_host_model host_inst (.clk_i(clk_sys_i), .sda_i(sda), .scl_o(scl),
    .sda_low_o(host_low));

  dcc_ctrl #(.ADDR_HI(5'h13), .ZERO_RUN(16)) dcc_ctrl_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n), .ce_i(ce), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
    .addr_strap_0_i(1'b0), .addr_strap_1_i(1'b1),
    .audio_bit_clock_i(audio_bit_clock), .audio_data_i(data),
    .frame_channel_clock_i(frame), .ctl_o(ctl), .zero_n_o(zero_n),
    .bus_busy_o(busy));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] s, input logic [7:0] d);
    host_inst.write_reg(DEV_W, s, d, 1'b0, acks);
    `CHK(acks, 3'b111)
    cyc(4);
  endtask

  task automatic bits(input logic v, input int n);
    @(posedge audio_bit_clock);
    #1 data = v;
    repeat (n) @(posedge audio_bit_clock);
    cyc(8);
  endtask

  task automatic done(input string n);
    $display("test %s done", n);
  endtask

  function automatic logic [16:0] fs_exp(input logic [1:0] g);
    logic [16:0] b;
    b = (g == 2'h0) ? `DCC_FS_GROUP_44K1 :
        (g == 2'h1) ? `DCC_FS_GROUP_48K : `DCC_FS_GROUP_32K;
    // Group and multiplier share the code in the loop below
    if (g == 2'h3) return 17'h0;
    return (g == 2'h1) ? b << 1 : (g == 2'h2) ? b >> 1 : b;
  endfunction

  task automatic tally_and_finish;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    failures++;
    tally_and_finish;
  end

  initial begin
    cyc(10);
    rst_n = 1'b1;
    cyc(10);
    `CHK(ctl.mclk_ratio, `DCC_RATIO_384)
    `CHK(ctl.fs_hz, `DCC_FS_GROUP_44K1)
    `CHK(ctl.left_gain, `DCC_GAIN_UNITY)
    `CHK(ctl.right_gain_code, 8'hff)
    `CHK({ctl.common_mode, ctl.common_attenuation_select, busy}, 3'h0)
    `CHK(zero_n, 1'b1)
    `CHK(ctl.mode_bits, `DCC_RST_MODE)
    done("reset");
    for (int i = 0; i < 4; i++) begin
      host_inst.write_reg(DEV_W, 8'h03, {i[1:0], i[1:0], i[0], 3'h0},
                          i < 3, acks);
      `CHK(acks, 3'b111)
      cyc(4);
      `CHK(ctl.fs_hz, fs_exp(i[1:0]))
      `CHK(ctl.mclk_ratio, i[0] ? `DCC_RATIO_256 : `DCC_RATIO_384)
      `CHK({ctl.rate_group, ctl.rate_multiplier}, {2{i[1:0]}})
      `CHK(ctl.output_clock_ratio_select, i[0])
    end
    `CHK(busy, 1'b0)
    done("rates");
    host_inst.start;
    `CHK(busy, 1'b1)
    host_inst.send_byte({5'h13, 2'b01, 1'b0}, ack);
    `CHK(ack, 1'b0)
    host_inst.send_byte(8'h03, ack);
    `CHK(ack, 1'b0)
    host_inst.send_byte(8'h00, ack);
    host_inst.stop;
    host_inst.write_reg(DEV_W | 8'h01, 8'h03, 8'h00, 1'b0, acks);
    `CHK(acks, 3'b000)
    host_inst.write_reg(DEV_W, 8'h07, 8'h00, 1'b1, acks);
    `CHK(acks, 3'b111)
    host_inst.send_byte(8'h00, ack);
    `CHK(ack, 1'b0)
    host_inst.stop;
    cyc(4);
    `CHK({ctl.rate_group, ctl.mclk_ratio}, {2'h3, `DCC_RATIO_256})
    done("refusal");
    for (int j = 0; j < 4; j++) begin
      wr(8'h03, {6'h00, j[1:0]});
      `CHK(ctl.serial_format_select, j[0])
      `CHK(ctl.frame_polarity_select, j[1])
      for (int f = 0; f < 2; f++) begin
        frame = f[0];
        cyc(6);
        `CHK(ctl.left_active, (j == 0) ? f[0] : ~f[0])
      end
    end
    // Enable low must freeze the frame synchroniser and the outputs
    ce = 1'b0;
    frame = 1'b0;
    cyc(6);
    `CHK(ctl.left_active, 1'b0)
    ce = 1'b1;
    cyc(6);
    `CHK(ctl.left_active, 1'b1)
    done("polarity");
    wr(8'h00, 8'h40);
    wr(8'h01, 8'h00);
    `CHK(ctl.left_gain_code, 8'hff)
    wr(8'h04, 8'h01);
    `CHK({ctl.left_gain_code, ctl.right_gain_code}, 16'h4000)
    `CHK({ctl.left_gain, ctl.right_gain}, {9'h040, 9'h000})
    wr(8'h03, 8'h04);
    `CHK(ctl.right_gain_code, 8'h40)
    `CHK(ctl.common_attenuation_select, 1'b1)
    wr(8'h00, 8'hff);
    `CHK({ctl.left_gain, ctl.right_gain}, {2{`DCC_GAIN_UNITY}})
    done("gain");
    wr(8'h04, 8'h02);
    `CHK({ctl.zero_detect_mute_enable, ctl.converter_disable}, 2'h2)
    bits(1'b0, 12);
    bits(1'b1, 2);
    `CHK({zero_n, ctl.common_mode}, 2'b10)
    bits(1'b0, 20);
    `CHK({zero_n, ctl.common_mode}, 2'b01)
    wr(8'h04, 8'h00);
    `CHK({zero_n, ctl.common_mode}, 2'b00)
    bits(1'b1, 2);
    `CHK(zero_n, 1'b1)
    wr(8'h04, 8'h04);
    `CHK(ctl.common_mode, 1'b1)
    `CHK(ctl.converter_disable, 1'b1)
    wr(8'h04, 8'h00);
    `CHK(ctl.common_mode, 1'b0)
    done("zero");
    wr(8'h02, 8'h5a);
    `CHK(ctl.mode_bits, 8'h5a)
    // Mid-run reset must bring the mode, format and output registers back to their defaults
    rst_n = 1'b0;
    cyc(10);
    rst_n = 1'b1;
    cyc(10);
    `CHK(ctl.mode_bits, `DCC_RST_MODE)
    `CHK(ctl.common_attenuation_select, 1'b0)
    `CHK({ctl.converter_disable, ctl.common_mode, busy}, 3'h0)
    `CHK(zero_n, 1'b1)
    done("reset again");
    tally_and_finish;
  end
endmodule
